// ---- rtl/ldm_pkg.sv ----
// Package for the LED dimming mode control block: offsets, fields, resets, timing.
// Assumes an 8-bit register port and a single 125 MHz clock.
package ldm_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ     = 125_000_000;
  localparam int LOW_TIMEOUT_MS  = 20;
  localparam int LOW_TIMEOUT_CYC = CLK_FREQ_HZ / 1000 * LOW_TIMEOUT_MS;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CFG       = 8'h00;
  localparam logic [7:0] ADDR_TP        = 8'h01;
  localparam logic [7:0] ADDR_GGAIN     = 8'h02;
  localparam logic [7:0] ADDR_GDUTY_L   = 8'h03;
  localparam logic [7:0] ADDR_GDUTY_H   = 8'h04;
  localparam logic [7:0] ADDR_LUM_L     = 8'h05;
  localparam logic [7:0] ADDR_LUM_H     = 8'h06;
  localparam logic [7:0] ADDR_STATUS    = 8'h07;
  localparam logic [7:0] ADDR_CGAIN     = 8'h08;
  localparam logic [7:0] ADDR_CDUTY_L   = 8'h0C;
  localparam logic [7:0] ADDR_CDUTY_H   = 8'h10;
  localparam logic [7:0] ADDR_RB_GAIN   = 8'h14;
  localparam logic [7:0] ADDR_RB_DUTY_L = 8'h18;
  localparam logic [7:0] ADDR_RB_DUTY_H = 8'h1C;

  // ==========================================================
  // Configuration field positions
  localparam int CFG_REG_SRC = 7;
  localparam int CFG_DIRECT  = 6;
  localparam int CFG_FDIM_LO = 3;
  localparam int CFG_EXP     = 2;
  localparam int CFG_MIXED   = 1;
  localparam int CFG_PERCH   = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [1:0] TP_RESET   = 2'h0;
  localparam logic [7:0] GAIN_RESET = 8'h80;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // ==========================================================
  // Arithmetic constants
  localparam logic [15:0] DUTY_FULL     = 16'hFFFF;
  localparam int          TP_SHIFT      = 13;
  localparam logic [23:0] EXP_ONE       = 24'hFFFFFF;
  localparam logic [23:0] EXP_FACTOR    = 24'hF60419;
  localparam logic [15:0] DIV3_MULT     = 16'h5556;
  localparam logic [15:0] PRESCALE_BASE = 16'h0080;
endpackage : ldm_pkg

// ---- rtl/ldm_meas.sv ----
// Dimming input measurement: synchroniser, period, duty and low timeout.
// Assumes the pin is asynchronous to ref_clk and slower than ref_clk / 20.
`timescale 1ns/100ps
module ldm_meas
  import ldm_pkg::*;
#(
  parameter int TIMEOUT_CYC = LOW_TIMEOUT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        pin_raw,
  output logic             pin_level,
  output logic             low_timeout,
  output logic [15:0]      duty,
  output logic [23:0]      period
);
  localparam logic [23:0] TMO = 24'(TIMEOUT_CYC);
  localparam logic [23:0] CMAX = 24'hFFFFFF;

  logic        sync1_reg, sync2_reg, last_reg, rise;
  logic [23:0] run_reg, high_reg, low_reg;
  logic [24:0] rem_reg, rem_sh;
  logic [15:0] quot_reg;
  logic [4:0]  bits_reg;

  // ==========================================================
  // Two-stage synchroniser, then edge history
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end
  assign pin_level = sync2_reg;
  assign rise      = sync2_reg & ~last_reg;

  // Period and high-time counters, restarted on each rising edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_reg  <= 24'h000000;
      high_reg <= 24'h000000;
      period   <= 24'h000000;
    end else if (clk_en) begin
      if (rise) begin
        period   <= run_reg;
        run_reg  <= 24'h000001;
        high_reg <= 24'h000001;
      end else begin
        run_reg  <= run_reg + 24'((run_reg != CMAX) ? 1 : 0);
        high_reg <= high_reg + 24'((sync2_reg && high_reg != CMAX) ? 1 : 0);
      end
    end
  end

  // Serial divide high/period into a 16-bit fraction
  assign rem_sh = {rem_reg[23:0], 1'b0};
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rem_reg  <= 25'h0000000;
      quot_reg <= 16'h0000;
      bits_reg <= 5'h00;
      duty     <= 16'h0000;
    end else if (clk_en) begin
      if (rise && run_reg != 24'h000000) begin
        if (high_reg >= run_reg) begin
          duty     <= DUTY_FULL;
          bits_reg <= 5'h00;
        end else begin
          rem_reg  <= {1'b0, high_reg};
          bits_reg <= 5'h10;
        end
      end else if (bits_reg != 5'h00) begin
        bits_reg <= bits_reg - 5'h01;
        if (rem_sh >= {1'b0, period}) begin
          rem_reg  <= rem_sh - {1'b0, period};
          quot_reg <= {quot_reg[14:0], 1'b1};
          if (bits_reg == 5'h01) duty <= {quot_reg[14:0], 1'b1};
        end else begin
          rem_reg  <= rem_sh;
          quot_reg <= {quot_reg[14:0], 1'b0};
          if (bits_reg == 5'h01) duty <= {quot_reg[14:0], 1'b0};
        end
      end else if (high_reg == TMO) begin
        duty <= DUTY_FULL;  // Stuck high reads as full duty
      end
    end
  end

  // Low-level timer for the switch-off condition
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      low_reg <= 24'h000000;
    end else if (clk_en) begin
      if (sync2_reg) low_reg <= 24'h000000;
      else if (low_reg != TMO) low_reg <= low_reg + 24'h000001;
    end
  end
  assign low_timeout = (low_reg == TMO);
endmodule : ldm_meas

// ---- rtl/ldm_expc.sv ----
// Exponential brightness curve: step i gives 0.961^(255-i) of full scale.
// Assumes the step input is held; a new value restarts an iterative multiply.
`timescale 1ns/100ps
module ldm_expc
  import ldm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [7:0]  step_in,
  output logic [15:0]      bright
);
  typedef enum logic {LDM_IDLE, LDM_RUN} ldm_exp_t;
  ldm_exp_t    state_reg;
  logic [23:0] acc_reg;
  logic [7:0]  left_reg, done_reg;
  logic        valid_reg;
  logic [47:0] prod;

  assign prod = acc_reg * EXP_FACTOR;

  // ==========================================================
  // One multiply by 0.961 per cycle, 255-i times
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= LDM_IDLE;
      acc_reg   <= EXP_ONE;
      left_reg  <= 8'h00;
      done_reg  <= 8'h00;
      valid_reg <= 1'b0;
      bright    <= 16'h0000;
    end else if (clk_en) begin
      unique case (state_reg)
        LDM_IDLE: begin
          if (!valid_reg || step_in != done_reg) begin
            acc_reg   <= EXP_ONE;
            left_reg  <= 8'hFF - step_in;
            done_reg  <= step_in;
            state_reg <= LDM_RUN;
          end
        end
        LDM_RUN: begin
          if (left_reg != 8'h00) begin
            acc_reg  <= prod[47:24];
            left_reg <= left_reg - 8'h01;
          end else begin
            bright    <= acc_reg[23:8];
            valid_reg <= 1'b1;
            state_reg <= LDM_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ldm_expc

// ---- rtl/ldm_top.sv ----
// LED dimming mode control: mode decode, mixed dimming, PWM and readback.
// Assumes one 125 MHz clock and an 8-bit register port with one-cycle read data.
//
// Contract
// - Input duty linear, global gain
// - Input low over 20 ms: outputs off
// - Input duty through exponential curve, global gain
// - Direct mode: rebuilt input drives outputs
// - Mixed: above point gain, below PWM
// - Below point duty equals brightness over gain
// - Input 8-bit duty, exponential, then mixed
// - Input duty linear, per-channel gain
// - Input duty exponential, per-channel gain
// - Direct mode with per-channel gain
// - Register duty pair applied unchanged
// - Low duty byte through exponential curve
// - Luminance pair linear, mixed dimming
// - Luminance low byte exponential, mixed dimming
// - Channel duty pairs, channel gains
// - Channel low bytes exponential, channel gains
// - Frequency from input or frequency field
// - Transition point 12.5 to 50 percent
// - Exponential curve 0.961 power steps
// - Applied gain and duty readable
`timescale 1ns/100ps
module ldm_top
  import ldm_pkg::*;
#(
  parameter int NCH         = 4,
  parameter int TIMEOUT_CYC = LOW_TIMEOUT_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             dimming_input_pin,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  output logic [NCH-1:0]        chan_pwm_out,
  output logic [NCH*8-1:0]      chan_gain_out,
  output logic                  outputs_off
);
  logic [7:0]  dimming_config_reg;
  logic [1:0]  transition_point_field;
  logic [7:0]  global_current_gain;
  logic [7:0]  global_duty_low, global_duty_high, lum_low, lum_high;
  logic [7:0]  channel_current_gain [NCH];
  logic [7:0]  channel_duty_low [NCH];
  logic [7:0]  channel_duty_high [NCH];
  logic [7:0]  applied_gain_readback [NCH];
  logic [15:0] applied_duty_readback [NCH];
  logic [15:0] bright [NCH];
  logic [15:0] exp_out [NCH];
  logic [15:0] duty_next [NCH];
  logic [7:0]  gain_next [NCH];
  logic [7:0]  exp_in [NCH];
  logic        above [NCH];
  logic        pin_level, low_timeout, off_now;
  logic [15:0] meas_duty, tp_level, prescale, pre_cnt_reg, phase_reg;
  logic [23:0] meas_period;
  logic        register_source_select, input_direct_pass, direct_mode;
  logic        exponential_curve_select, mixed_dimming_select, per_channel_select;
  logic [2:0]  fdim;
  logic [1:0]  idx;

  // ==========================================================
  // Configuration field decode
  // configuration bit layout
  assign register_source_select   = dimming_config_reg[CFG_REG_SRC];
  assign input_direct_pass        = dimming_config_reg[CFG_DIRECT];
  assign fdim                     = dimming_config_reg[CFG_FDIM_LO +: 3];
  assign exponential_curve_select = dimming_config_reg[CFG_EXP];
  assign mixed_dimming_select     = dimming_config_reg[CFG_MIXED] & ~dimming_config_reg[CFG_PERCH];
  assign per_channel_select       = dimming_config_reg[CFG_PERCH];
  assign direct_mode              = input_direct_pass & ~register_source_select;
  assign off_now                  = ~register_source_select & low_timeout;
  assign tp_level = 16'(({14'h0000, transition_point_field} + 16'h0001) << TP_SHIFT);
  assign idx      = reg_addr[1:0];

  // ==========================================================
  // Register writes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dimming_config_reg     <= CFG_RESET;
      transition_point_field <= TP_RESET;
      global_current_gain    <= GAIN_RESET;
      global_duty_low        <= DUTY_RESET;
      global_duty_high       <= DUTY_RESET;
      lum_low                <= DUTY_RESET;
      lum_high               <= DUTY_RESET;
      for (int c = 0; c < NCH; c++) begin
        channel_current_gain[c] <= GAIN_RESET;
        channel_duty_low[c]     <= DUTY_RESET;
        channel_duty_high[c]    <= DUTY_RESET;
      end
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        ADDR_CFG:     dimming_config_reg     <= reg_wdata;
        ADDR_TP:      transition_point_field <= reg_wdata[1:0];
        ADDR_GGAIN:   global_current_gain    <= reg_wdata;
        ADDR_GDUTY_L: global_duty_low        <= reg_wdata;
        ADDR_GDUTY_H: global_duty_high       <= reg_wdata;
        ADDR_LUM_L:   lum_low                <= reg_wdata;
        ADDR_LUM_H:   lum_high               <= reg_wdata;
        default: begin
          if (reg_addr[7:2] == ADDR_CGAIN[7:2]) channel_current_gain[idx] <= reg_wdata;
          if (reg_addr[7:2] == ADDR_CDUTY_L[7:2]) channel_duty_low[idx] <= reg_wdata;
          if (reg_addr[7:2] == ADDR_CDUTY_H[7:2]) channel_duty_high[idx] <= reg_wdata;
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CFG:     reg_rdata <= dimming_config_reg;
          ADDR_TP:      reg_rdata <= {6'h00, transition_point_field};
          ADDR_GGAIN:   reg_rdata <= global_current_gain;
          ADDR_GDUTY_L: reg_rdata <= global_duty_low;
          ADDR_GDUTY_H: reg_rdata <= global_duty_high;
          ADDR_LUM_L:   reg_rdata <= lum_low;
          ADDR_LUM_H:   reg_rdata <= lum_high;
          ADDR_STATUS:  reg_rdata <= {6'h00, outputs_off, pin_level};
          default: begin
            if (reg_addr[7:2] == ADDR_CGAIN[7:2]) reg_rdata <= channel_current_gain[idx];
            if (reg_addr[7:2] == ADDR_CDUTY_L[7:2]) reg_rdata <= channel_duty_low[idx];
            if (reg_addr[7:2] == ADDR_CDUTY_H[7:2]) reg_rdata <= channel_duty_high[idx];
            if (reg_addr[7:2] == ADDR_RB_GAIN[7:2]) reg_rdata <= applied_gain_readback[idx];
            if (reg_addr[7:2] == ADDR_RB_DUTY_L[7:2])
              reg_rdata <= applied_duty_readback[idx][7:0];
            if (reg_addr[7:2] == ADDR_RB_DUTY_H[7:2])
              reg_rdata <= applied_duty_readback[idx][15:8];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Input measurement
  ldm_meas #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_meas (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .pin_raw     (dimming_input_pin),
    .pin_level   (pin_level),
    .low_timeout (low_timeout),
    .duty        (meas_duty),
    .period      (meas_period)
  );

  // ==========================================================
  // Per-channel brightness, mixed split and gain selection
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [18:0] scaled;
    logic [34:0] div3;
    logic [18:0] below;

    // register low byte selects the curve step; the measured input uses its high byte
    assign exp_in[c] = !register_source_select ? meas_duty[15:8] :
                       per_channel_select      ? channel_duty_low[c] :
                       mixed_dimming_select    ? lum_low : global_duty_low;

    ldm_expc u_expc (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .step_in (exp_in[c]),
      .bright  (exp_out[c])
    );

    always_comb begin
      if (exponential_curve_select) bright[c] = exp_out[c];
      else if (!register_source_select) bright[c] = meas_duty;
      else if (per_channel_select) bright[c] = {channel_duty_high[c], channel_duty_low[c]};
      else if (mixed_dimming_select) bright[c] = {lum_high, lum_low};
      else bright[c] = {global_duty_high, global_duty_low};
    end

    // duty is brightness over gain fraction
    assign scaled = {bright[c], 3'b000};
    assign div3   = scaled * DIV3_MULT;
    always_comb begin
      unique case (transition_point_field)
        2'h0: below = scaled;
        2'h1: below = {1'b0, scaled[18:1]};
        2'h2: below = div3[34:16];
        2'h3: below = {2'b00, scaled[18:2]};
      endcase
    end
    assign above[c] = bright[c] >= tp_level;

    always_comb begin
      if (mixed_dimming_select) begin
        gain_next[c] = above[c] ? bright[c][15:8] : tp_level[15:8];
        duty_next[c] = above[c] ? DUTY_FULL : ((below[18:16] != 3'h0) ? DUTY_FULL : below[15:0]);
      end else begin
        gain_next[c] = per_channel_select ? channel_current_gain[c] : global_current_gain;
        duty_next[c] = bright[c];
      end
    end
    assign chan_gain_out[c*8 +: 8] = applied_gain_readback[c];
  end

  // ==========================================================
  // Dimming frequency prescaler and shared phase counter
  // frequency from input or field
  assign prescale = register_source_select ? (PRESCALE_BASE >> fdim) :
                    (meas_period[23:16] == 8'h00) ? 16'h0001 : {8'h00, meas_period[23:16]};
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pre_cnt_reg <= 16'h0000;
      phase_reg   <= 16'h0000;
    end else if (clk_en) begin
      if (pre_cnt_reg == 16'h0000) begin
        pre_cnt_reg <= prescale - 16'h0001;
        phase_reg   <= phase_reg + 16'h0001;
      end else begin
        pre_cnt_reg <= pre_cnt_reg - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Applied values and output drive
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      outputs_off  <= 1'b0;
      chan_pwm_out <= '0;
      for (int c = 0; c < NCH; c++) begin
        applied_gain_readback[c] <= GAIN_RESET;
        applied_duty_readback[c] <= 16'h0000;
      end
    end else if (clk_en) begin
      outputs_off <= off_now;
      for (int c = 0; c < NCH; c++) begin
        applied_gain_readback[c] <= gain_next[c];
        if (off_now) begin
          applied_duty_readback[c] <= 16'h0000;
          chan_pwm_out[c]          <= 1'b0;
        end else if (direct_mode) begin
          applied_duty_readback[c] <= meas_duty;
          chan_pwm_out[c]          <= pin_level;
        end else begin
          applied_duty_readback[c] <= duty_next[c];
          chan_pwm_out[c]          <= (duty_next[c] == DUTY_FULL) || (phase_reg < duty_next[c]);
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  cfg_write_a: assert property (clk_en && reg_wr && reg_addr == ADDR_CFG |=>
    dimming_config_reg == $past(reg_wdata)) else $error("config write lost");
  timeout_off_a: assert property (clk_en && off_now |=>
    chan_pwm_out == '0 && outputs_off) else $error("outputs not off after timeout");
  direct_pass_a: assert property (clk_en && direct_mode && !off_now |=>
    chan_pwm_out == {NCH{$past(pin_level)}}) else $error("direct pass mismatch");
  mixed_above_a: assert property (clk_en && mixed_dimming_select && above[0]
    && !off_now && !direct_mode |=> applied_duty_readback[0] == DUTY_FULL)
    else $error("mixed above duty not full");
  tp_gain_a: assert property (clk_en && mixed_dimming_select && !above[0] |=>
    applied_gain_readback[0] == $past(tp_level[15:8])) else $error("gain not at point");
  mixed_ratio_a: assert property (clk_en && mixed_dimming_select && !above[0]
    && transition_point_field == 2'h1 && !off_now && !direct_mode
    |=> applied_duty_readback[0] == 16'($past(bright[0]) << 2))
    else $error("mixed duty ratio wrong");
  perch_gain_a: assert property (clk_en && per_channel_select |=>
    chan_gain_out[15:8] == $past(channel_current_gain[1])) else $error("channel gain wrong");
  global_gain_a: assert property (clk_en && !per_channel_select && !mixed_dimming_select
    |=> chan_gain_out[23:16] == $past(global_current_gain)) else $error("global gain wrong");
  reg_duty_a: assert property (clk_en && register_source_select && !per_channel_select
    && !mixed_dimming_select && !exponential_curve_select
    |=> applied_duty_readback[2] == $past({global_duty_high, global_duty_low}))
    else $error("register duty not passed");
  rb_read_a: assert property (clk_en && reg_rd && reg_addr == ADDR_RB_GAIN |=>
    reg_rdata == $past(applied_gain_readback[0])) else $error("gain readback wrong");

  mixed_below_c: cover property (clk_en && mixed_dimming_select && !above[0] ##1 clk_en);
  timeout_c: cover property (off_now ##1 !off_now);
  direct_c: cover property (clk_en && direct_mode && pin_level);
  expo_c: cover property (clk_en && exponential_curve_select && register_source_select);
endmodule : ldm_top

// ---- verif/ldm_host_model.sv ----
// Host model: drives the dimming input pin with a fixed pulse train.
// Assumes the bench changes the counts and the run flag just after a clock edge.
`timescale 1ns/100ps
module ldm_host_model (
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        idle_level,
  input  wire logic [15:0] high_cyc,
  input  wire logic [15:0] low_cyc,
  output logic             pin
);
  logic [15:0] cnt_reg;
  // ==========================================================
  // Pulse train while running, a set level while idle
  always @(posedge ref_clk) begin
    if (!run) begin
      pin     <= idle_level;
      cnt_reg <= 16'h0000;
    end else if (cnt_reg == 16'h0000) begin
      pin     <= !pin;
      cnt_reg <= (pin ? low_cyc : high_cyc) - 16'h0001;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
endmodule : ldm_host_model

// ---- verif/tb_led_dimming_mode_control.sv ----
// Testbench for the dimming mode block: register port, modes, input pin.
// Assumes the host model on the pin and a shortened low timeout.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
`define WAITC(c, n) for (wi = 0; wi < (n) && (c) !== 1'b1; wi++) settle(1); \
  if ((c) !== 1'b1) begin n_errors++; summarize(); end
module tb_led_dimming_mode_control;
  import ldm_pkg::*;
  logic        ref_clk, reset, clk_en, reg_wr, reg_rd, run, idle_level, pin, outputs_off;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  chan_pwm_out;
  logic [31:0] chan_gain_out;
  logic [15:0] high_cyc, low_cyc;
  int          n_errors, check_count, wi;
  ldm_top #(.NCH(4), .TIMEOUT_CYC(200)) dut_u (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .dimming_input_pin(pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_pwm_out(chan_pwm_out),
    .chan_gain_out(chan_gain_out), .outputs_off(outputs_off));
  ldm_host_model host_u (.ref_clk(ref_clk), .run(run), .idle_level(idle_level),
    .high_cyc(high_cyc), .low_cyc(low_cyc), .pin(pin));
  // ==========================================================
  // Bus and timing helpers
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // ==========================================================
  // reset values, unmapped and read-only places
  task automatic t_reset();
    rd(ADDR_CFG, CFG_RESET);
    rd(ADDR_GGAIN, GAIN_RESET);
    wr(ADDR_RB_GAIN, 8'h55);
    rd(ADDR_RB_GAIN, 8'h80);
    rd(8'hFF, 8'h00);
    // Clock enable low: a write must not land
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(ADDR_CFG, 8'h55);
    @(posedge ref_clk) clk_en <= 1'b1;
    rd(ADDR_CFG, CFG_RESET);
    $display("test reset done");
  endtask : t_reset
  // register duty, global and per-channel gains
  task automatic t_regs();
    wr(ADDR_CFG, 8'h80);
    wr(ADDR_GGAIN, 8'h40);
    wr(ADDR_GDUTY_H, 8'hFF);
    wr(ADDR_GDUTY_L, 8'hFF);
    settle(3);
    `CHK(chan_gain_out, 32'h40404040)
    `CHK(chan_pwm_out, 4'hF)
    rd(ADDR_RB_DUTY_H + 8'h03, 8'hFF);
    wr(ADDR_CFG, 8'h81);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CGAIN + 8'(c), 8'h10 + 8'(c));
      wr(ADDR_CDUTY_H + 8'(c), c[0] ? 8'hFF : 8'h00);
      wr(ADDR_CDUTY_L + 8'(c), c[0] ? 8'hFF : 8'h00);
    end
    settle(3);
    `CHK(chan_gain_out, 32'h13121110)
    `CHK(chan_pwm_out, 4'hA)
    $display("test regs done");
  endtask : t_regs
  // mixed dimming over every transition code
  task automatic t_mixed();
    wr(ADDR_CFG, 8'h82);
    wr(ADDR_LUM_H, 8'h10);
    wr(ADDR_LUM_L, 8'h00);
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_TP, 8'(t));
      settle(3);
      rd(ADDR_RB_GAIN, 8'(32 * (t + 1)));
      rd(ADDR_RB_DUTY_H, 8'(128 / (t + 1)));
    end
    wr(ADDR_LUM_H, 8'h90);
    settle(3);
    rd(ADDR_RB_GAIN, 8'h90);
    `CHK(chan_pwm_out, 4'hF)
    $display("test mixed done");
  endtask : t_mixed
  // curve end points through the low duty byte
  task automatic t_exp();
    wr(ADDR_CFG, 8'h84);
    wr(ADDR_GDUTY_L, 8'hFF);
    settle(300);
    rd(ADDR_RB_DUTY_H, 8'hFF);
    wr(ADDR_GDUTY_L, 8'h00);
    settle(300);
    rd(ADDR_RB_DUTY_H, 8'h00);
    wr(ADDR_CFG, 8'h86);
    wr(ADDR_LUM_L, 8'hFF);
    settle(300);
    rd(ADDR_RB_GAIN, 8'hFF);
    wr(ADDR_CFG, 8'h85);
    settle(300);
    rd(ADDR_RB_DUTY_H + 8'h01, 8'hFF);
    rd(ADDR_RB_DUTY_H, 8'h00);
    $display("test exp done");
  endtask : t_exp
  task automatic t_direct();
    wr(ADDR_CFG, 8'h41);
    settle(3);
    `CHK(chan_gain_out, 32'h13121110)
    @(posedge ref_clk) idle_level <= 1'b0;
    `WAITC(chan_pwm_out == 4'h0, 10)
    @(posedge ref_clk) idle_level <= 1'b1;
    `WAITC(chan_pwm_out == 4'hF, 10)
    $display("test direct done");
  endtask : t_direct
  // measured input duty, then low timeout
  task automatic t_input();
    int hc;
    wr(ADDR_CFG, 8'h00);
    @(posedge ref_clk) run <= 1'b1;
    settle(2000);
    rd(ADDR_RB_DUTY_H, 8'h40);
    `CHK(chan_gain_out, 32'h40404040)
    `CHK(outputs_off, 1'b0)
    // one PWM period at input-derived rate
    hc = 0;
    repeat (65536) begin
      settle(1);
      if (chan_pwm_out[0] === 1'b1) hc++;
    end
    `CHK(hc, 16384)
    wr(ADDR_CFG, 8'h02);
    settle(3);
    rd(ADDR_RB_GAIN, 8'h80);
    rd(ADDR_RB_DUTY_H, 8'h80);
    run <= 1'b0;
    idle_level <= 1'b0;
    `WAITC(outputs_off, 400)
    `CHK(chan_pwm_out, 4'h0)
    @(posedge ref_clk) idle_level <= 1'b1;
    `WAITC(!outputs_off, 20)
    $display("test input done");
  endtask : t_input
  // ==========================================================
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    {reset, idle_level, clk_en} = 3'b111;
    {reg_wr, reg_rd, run} = 3'b000;
    {reg_addr, reg_wdata} = 16'h0000;
    high_cyc = 16'h0032;
    low_cyc = 16'h0096;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_mixed();
    t_exp();
    t_direct();
    t_input();
    summarize();
  end
endmodule : tb_led_dimming_mode_control
